// ===== ivp_pkg.sv
// Constants for the interrupt vector, priority and exception window block.
// Assumes a 16-bit register port addressed by word index.
package ivw_pkg;
  localparam int unsigned DW      = 16;
  localparam int unsigned AW      = 4;
  localparam int unsigned NGRP    = 16;
  localparam int unsigned LVLW    = 2;
  localparam int unsigned VECW    = 8;
  localparam int unsigned NMISC   = 7;

  // Register indices
  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_PRIO_LOW = 4'h1;
  localparam logic [3:0] ADDR_PRIO_HI  = 4'h2;
  localparam logic [3:0] ADDR_PREFIX   = 4'h3;
  localparam logic [3:0] ADDR_STATUS   = 4'h4;
  localparam logic [3:0] ADDR_MASK     = 4'h5;
  localparam logic [3:0] ADDR_SERVICE  = 4'h6;

  // Control register bit positions
  localparam int unsigned CTRL_GLOBAL_BIT = 0;
  localparam int unsigned CTRL_PF_BIT     = 1;
  localparam int unsigned CTRL_MEM_BIT    = 2;
  localparam int unsigned CTRL_SPI0_BIT   = 3;
  localparam int unsigned CTRL_SPI1_BIT   = 4;
  localparam int unsigned CTRL_W          = 5;

  // Status and mask bit positions
  localparam int unsigned ST_TAKEN_BIT    = 0;
  localparam int unsigned ST_DEFER_BIT    = 1;
  localparam int unsigned ST_W            = 2;

  // Natural priority groups with fixed sources, and the first reserved one
  localparam int unsigned GRP_PF   = 0;
  localparam int unsigned GRP_MEM  = 1;
  localparam int unsigned GRP_SPI0 = 5;
  localparam int unsigned GRP_SPI1 = 10;
  localparam int unsigned GRP_RSV0 = 11;

  // Groups fed by pre-enabled peripheral requests, in input bit order
  localparam int unsigned MISC_GRP [NMISC] = '{2, 3, 4, 6, 7, 8, 9};

  // Vector table: base plus fixed step per natural priority
  localparam logic [VECW-1:0] VEC_BASE = 8'h20;
  localparam logic [VECW-1:0] VEC_STEP = 8'h08;

  // Reset values
  localparam logic [DW-1:0]   PRIO_RST = 16'h0000;
  localparam logic [LVLW-1:0] SVC_IDLE = 2'h3;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [ST_W-1:0]   ST_RST   = 2'h0;
endpackage : ivw_pkg

// ===== ivp_src_gate.sv
// One interrupt source group: merges its flags and applies the enables.
// Assumes flags come from logic on the same clock.
`timescale 1ns/1ps
module ivw_src_gate #(
  parameter int unsigned W             = 1,
  parameter bit          GLOBAL_EXEMPT = 1'b0
) (
  input  wire logic [W-1:0] i_flags,
  input  wire logic         i_local_en,
  input  wire logic         i_global_en,
  output logic              o_req
);
  // Any flag raises the group; the power-fail group skips the global gate
  always_comb
  begin
    if (GLOBAL_EXEMPT)
    begin
      o_req = (|i_flags) & i_local_en;
    end
    else
    begin
      o_req = (|i_flags) & i_local_en & i_global_en;
    end
  end
endmodule : ivw_src_gate

// ===== ivp_ctrl.sv
// Interrupt request gating, vector mapping, priority pick and
// exception window for a 16-bit core.
// Assumes flags, core strobes and the register port share i_clk.
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module ivw_ctrl (
  input  wire logic                      i_clk,
  input  wire logic                      i_srst,
  // Register port
  input  wire logic [ivw_pkg::AW-1:0]    i_addr,
  input  wire logic [ivw_pkg::DW-1:0]    i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic      [ivw_pkg::DW-1:0]    o_rdata,
  // Peripheral flags
  input  wire logic                      i_powerfail_irq_flag,
  input  wire logic                      i_user_read_fault_flag,
  input  wire logic                      i_user_write_fault_flag,
  input  wire logic                      i_system_read_fault_flag,
  input  wire logic                      i_system_write_fault_flag,
  input  wire logic [3:0]                i_spi0_flags,
  input  wire logic [3:0]                i_spi1_flags,
  input  wire logic [ivw_pkg::NMISC-1:0] i_misc_req,
  // Core side
  input  wire logic                      i_code_pointer_access,
  input  wire logic                      i_return_from_interrupt,
  output logic                           o_take,
  output logic      [ivw_pkg::VECW-1:0]  o_vector,
  output logic      [ivw_pkg::LVLW-1:0]  o_in_service_priority_status,
  output logic      [ivw_pkg::DW-1:0]    o_prefix_register,
  output logic                           o_prefix_valid,
  output logic                           o_irq
);

  logic [ivw_pkg::CTRL_W-1:0] ctrl;
  logic [ivw_pkg::DW-1:0]     priority_ctrl_low;
  logic [ivw_pkg::DW-1:0]     priority_ctrl_high;
  logic [ivw_pkg::ST_W-1:0]   status;
  logic [ivw_pkg::ST_W-1:0]   mask;
  logic [ivw_pkg::LVLW-1:0]   svc_lvl;
  logic [ivw_pkg::NGRP-1:0]   grp_req;
  logic [ivw_pkg::NGRP-1:0]   req_q;
  logic                       window_q;
  logic                       take_hold_q;
  logic                       window_now;
  logic                       cand_valid;
  logic [3:0]                 cand_grp;
  logic [ivw_pkg::LVLW-1:0]   cand_lvl;
  logic                       do_take;
  logic                       wr_prefix;
  logic [ivw_pkg::ST_W-1:0]   next_status;
  logic [ivw_pkg::ST_W-1:0]   st_event;

  assign wr_prefix = i_wr && (i_addr == ivw_pkg::ADDR_PREFIX);

  // Power-fail group: own enable only
  ivw_src_gate #(
    .W             (1),
    .GLOBAL_EXEMPT (1'b1)
  ) u_gate_pf (
    .i_flags     (i_powerfail_irq_flag),
    .i_local_en  (ctrl[ivw_pkg::CTRL_PF_BIT]),
    .i_global_en (ctrl[ivw_pkg::CTRL_GLOBAL_BIT]),
    .o_req       (grp_req[ivw_pkg::GRP_PF])
  );

  // Memory fault group: four flags merged under protection enable
  ivw_src_gate #(
    .W             (4),
    .GLOBAL_EXEMPT (1'b0)
  ) u_gate_mem (
    .i_flags     ({i_system_write_fault_flag, i_system_read_fault_flag,
                   i_user_write_fault_flag, i_user_read_fault_flag}),
    .i_local_en  (ctrl[ivw_pkg::CTRL_MEM_BIT]),
    .i_global_en (ctrl[ivw_pkg::CTRL_GLOBAL_BIT]),
    .o_req       (grp_req[ivw_pkg::GRP_MEM])
  );

  // First serial port: mode fault, collision, overrun, complete
  ivw_src_gate #(
    .W             (4),
    .GLOBAL_EXEMPT (1'b0)
  ) u_gate_spi0 (
    .i_flags     (i_spi0_flags),
    .i_local_en  (ctrl[ivw_pkg::CTRL_SPI0_BIT]),
    .i_global_en (ctrl[ivw_pkg::CTRL_GLOBAL_BIT]),
    .o_req       (grp_req[ivw_pkg::GRP_SPI0])
  );

  // Second serial port, same flag set
  ivw_src_gate #(
    .W             (4),
    .GLOBAL_EXEMPT (1'b0)
  ) u_gate_spi1 (
    .i_flags     (i_spi1_flags),
    .i_local_en  (ctrl[ivw_pkg::CTRL_SPI1_BIT]),
    .i_global_en (ctrl[ivw_pkg::CTRL_GLOBAL_BIT]),
    .o_req       (grp_req[ivw_pkg::GRP_SPI1])
  );

  // Other groups arrive already locally enabled; only the global gate
  genvar gi;
  generate
    for (gi = 0; gi < ivw_pkg::NMISC; gi++)
    begin : g_misc
      ivw_src_gate #(
        .W             (1),
        .GLOBAL_EXEMPT (1'b0)
      ) u_gate (
        .i_flags     (i_misc_req[gi]),
        .i_local_en  (1'b1),
        .i_global_en (ctrl[ivw_pkg::CTRL_GLOBAL_BIT]),
        .o_req       (grp_req[ivw_pkg::MISC_GRP[gi]])
      );
    end
  endgenerate

  // Reserved slots carry no source
  assign grp_req[ivw_pkg::NGRP-1:ivw_pkg::GRP_RSV0] = '0;

  // Requests sampled on the rising edge, picked one cycle later
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      req_q <= '0;
    end
    else
    begin
      req_q <= grp_req;
    end
  end

  // Window opens the cycle after a prefix write
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      window_q <= 1'b0;
    end
    else
    begin
      window_q <= wr_prefix;
    end
  end

  // A code-pointer code fetch makes its own cycle non-interruptible,
  // since the same instruction may be touching the stack
  assign window_now = window_q | i_code_pointer_access;

  // Pick: lowest level first, lowest group number among equals.
  // A level of 3 never beats the idle status, so it disables a group.
  always_comb
  begin
    logic [ivw_pkg::LVLW-1:0] lvl;
    lvl        = '0;
    cand_valid = 1'b0;
    cand_grp   = '0;
    cand_lvl   = ivw_pkg::SVC_IDLE;
    for (int g = 0; g < ivw_pkg::NGRP; g++)
    begin
      if (g < 8)
      begin
        lvl = priority_ctrl_low[2*g +: 2];
      end
      else
      begin
        lvl = priority_ctrl_high[2*(g-8) +: 2];
      end
      // Strict compare keeps first-found on ties
      if (req_q[g] && (lvl < cand_lvl))
      begin
        cand_valid = 1'b1;
        cand_grp   = 4'(g);
        cand_lvl   = lvl;
      end
    end
  end

  // Preempt only at a strictly higher level than the one in service;
  // no take in a window, during a return, or while a take settles
  assign do_take = cand_valid && (cand_lvl < svc_lvl)
                   && !window_now
                   && !i_return_from_interrupt
                   && !take_hold_q;

  // A request blocked by the window stays in req_q and is taken the
  // following cycle, since the window is only one cycle long
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      take_hold_q <= 1'b0;
    end
    else
    begin
      take_hold_q <= do_take;
    end
  end

  // Take pulse and vector toward the core
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_take   <= 1'b0;
      o_vector <= ivw_pkg::VEC_BASE;
    end
    else
    begin
      o_take <= do_take;
      if (do_take)
      begin
        o_vector <= ivw_pkg::VEC_BASE
                    + 8'(cand_grp * ivw_pkg::VEC_STEP);
      end
    end
  end

  // Service level: loaded on entry, back to idle on return
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      svc_lvl <= ivw_pkg::SVC_IDLE;
    end
    else if (do_take)
    begin
      svc_lvl <= cand_lvl;
    end
    else if (i_return_from_interrupt)
    begin
      svc_lvl <= ivw_pkg::SVC_IDLE;
    end
  end

  assign o_in_service_priority_status = svc_lvl;

  // Prefix value lives for exactly one cycle after the write
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_prefix_register <= '0;
      o_prefix_valid    <= 1'b0;
    end
    else
    begin
      o_prefix_valid <= wr_prefix;
      if (wr_prefix)
      begin
        o_prefix_register <= i_wdata;
      end
      else
      begin
        o_prefix_register <= '0;
      end
    end
  end

  // Control and priority registers
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      ctrl               <= ivw_pkg::CTRL_RST;
      priority_ctrl_low  <= ivw_pkg::PRIO_RST;
      priority_ctrl_high <= ivw_pkg::PRIO_RST;
      mask               <= ivw_pkg::ST_RST;
    end
    else if (i_wr)
    begin
      unique case (i_addr)
        ivw_pkg::ADDR_CTRL:     ctrl <= i_wdata[ivw_pkg::CTRL_W-1:0];
        ivw_pkg::ADDR_PRIO_LOW: priority_ctrl_low <= i_wdata;
        ivw_pkg::ADDR_PRIO_HI:  priority_ctrl_high <= i_wdata;
        ivw_pkg::ADDR_MASK:     mask <= i_wdata[ivw_pkg::ST_W-1:0];
        default:                ;
      endcase
    end
  end

  // Sticky events: a take, and a request held off by a window
  assign st_event[ivw_pkg::ST_TAKEN_BIT] = do_take;
  assign st_event[ivw_pkg::ST_DEFER_BIT] = cand_valid && window_now
                                           && (cand_lvl < svc_lvl);

  // Set wins over a write-one clear in the same cycle
  always_comb
  begin
    next_status = status;
    if (i_wr && (i_addr == ivw_pkg::ADDR_STATUS))
    begin
      next_status = status & ~i_wdata[ivw_pkg::ST_W-1:0];
    end
    next_status = next_status | st_event;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      status <= ivw_pkg::ST_RST;
    end
    else
    begin
      status <= next_status;
    end
  end

  // Level interrupt while any unmasked status bit stands
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_irq <= 1'b0;
    end
    else
    begin
      o_irq <= |(next_status & mask);
    end
  end

  // Read data stand the cycle after the strobe; unmapped reads as zero
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_rdata <= '0;
    end
    else if (i_rd)
    begin
      unique case (i_addr)
        ivw_pkg::ADDR_CTRL:     o_rdata <= 16'(ctrl);
        ivw_pkg::ADDR_PRIO_LOW: o_rdata <= priority_ctrl_low;
        ivw_pkg::ADDR_PRIO_HI:  o_rdata <= priority_ctrl_high;
        ivw_pkg::ADDR_STATUS:   o_rdata <= 16'(status);
        ivw_pkg::ADDR_MASK:     o_rdata <= 16'(mask);
        ivw_pkg::ADDR_SERVICE:  o_rdata <= {8'h00, 4'(cand_grp),
                                            cand_valid, 1'b0, svc_lvl};
        default:                o_rdata <= '0;
      endcase
    end
    else
    begin
      o_rdata <= '0;
    end
  end

endmodule : ivw_ctrl

// ===== ivp_ctrl_properties.sv
// Timing checks on the interrupt block's ports.
// Assumes one clock and the synchronous active-high reset.
`timescale 1ns/1ps
module ivw_ctrl_properties (
  input wire logic        i_clk,
  input wire logic        i_srst,
  input wire logic [3:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_code_pointer_access,
  input wire logic        i_return_from_interrupt,
  input wire logic        o_take,
  input wire logic [7:0]  o_vector,
  input wire logic [1:0]  o_in_service_priority_status,
  input wire logic [15:0] o_prefix_register,
  input wire logic        o_prefix_valid
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  // Prefix write seen as one cycle of value, then a blocked decision
  sequence s_prefix_wr;
    i_wr && i_addr == ivw_pkg::ADDR_PREFIX;
  endsequence
  a_prefix_value: assert property (s_prefix_wr |=> o_prefix_valid
    && o_prefix_register == $past(i_wdata)) else $error("prefix lost");
  a_prefix_cause: assert property (o_prefix_valid |->
    $past(i_wr && i_addr == ivw_pkg::ADDR_PREFIX)) else $error("stale prefix");
  a_prefix_window: assert property (s_prefix_wr |=> ##1 !o_take)
    else $error("take inside prefix window");
  a_codeptr_window: assert property (i_code_pointer_access |=> !o_take)
    else $error("take inside code pointer window");
  a_take_gap: assert property (o_take |=> !o_take)
    else $error("takes back to back");
  a_return_idle: assert property (i_return_from_interrupt |=>
    o_in_service_priority_status == ivw_pkg::SVC_IDLE && !o_take)
    else $error("return did not idle service level");
  a_level_cause: assert property (!$stable(o_in_service_priority_status)
    |-> o_take || $past(i_return_from_interrupt))
    else $error("service level moved without cause");
  a_take_preempt: assert property (o_take |->
    o_in_service_priority_status < $past(o_in_service_priority_status))
    else $error("take without strictly higher level");
  a_vector_map: assert property (o_take |-> o_vector[2:0] == 3'h0
    && o_vector >= 8'h20 && o_vector <= 8'h98) else $error("bad vector");
  a_vector_hold: assert property (!o_take |-> $stable(o_vector))
    else $error("vector moved without take");
  c_take: cover property (o_take);
  c_prefix: cover property (s_prefix_wr ##2 o_take);
  c_codeptr: cover property (i_code_pointer_access ##2 o_take);
  c_return: cover property (i_return_from_interrupt);
endmodule : ivw_ctrl_properties

bind ivw_ctrl ivw_ctrl_properties i_ivw_ctrl_properties (
  .i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_code_pointer_access(i_code_pointer_access),
  .i_return_from_interrupt(i_return_from_interrupt), .o_take(o_take),
  .o_vector(o_vector),
  .o_in_service_priority_status(o_in_service_priority_status),
  .o_prefix_register(o_prefix_register), .o_prefix_valid(o_prefix_valid)
);

// ===== ivp_core_model.sv
// Core stand-in: runs a service routine and then returns.
// Assumes the take pulse is one cycle long on the shared clock.
`timescale 1ns/1ps
module ivw_core_model (
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic       i_take,
  input  wire logic [2:0] i_delay,
  output logic            o_ret
);
  int cnt;
  // Routine length set per take, so returns come promptly or slowly
  always_ff @(posedge i_clk)
  begin
    o_ret <= 1'b0;
    if (i_srst)
      cnt <= 0;
    else if (i_take)
      cnt <= int'(i_delay) + 1;
    else if (cnt > 1)
      cnt <= cnt - 1;
    else if (cnt == 1)
    begin
      cnt   <= 0;
      o_ret <= 1'b1;
    end
  end
endmodule : ivw_core_model

// ===== tb_interrupt_vector_priority_window.sv
// Self-checking bench for the interrupt selection and window block.
// Assumes the register map and latencies of the design's package.
`timescale 1ns/1ps
module tb_interrupt_vector_priority_window;
  logic        i_clk, i_srst, i_wr, i_rd, pf, urf, uwf, srf, swf, cpa, ret;
  logic        take, prefix_ok, irq;
  logic [3:0]  i_addr, spi0, spi1;
  logic [15:0] i_wdata, o_rdata, prefix_val, d, m;
  logic [6:0]  misc;
  logic [7:0]  vec;
  logic [1:0]  svc_lvl;
  logic [2:0]  dly;
  logic [4:0]  ctl;
  logic [31:0] s = 32'h75a5;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          lv [16];
  int          n, e;

  ivw_ctrl i_ivw_ctrl (.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_powerfail_irq_flag(pf), .i_user_read_fault_flag(urf),
    .i_user_write_fault_flag(uwf), .i_system_read_fault_flag(srf),
    .i_system_write_fault_flag(swf), .i_spi0_flags(spi0),
    .i_spi1_flags(spi1), .i_misc_req(misc), .i_code_pointer_access(cpa),
    .i_return_from_interrupt(ret), .o_take(take), .o_vector(vec),
    .o_in_service_priority_status(svc_lvl), .o_prefix_register(prefix_val),
    .o_prefix_valid(prefix_ok), .o_irq(irq));
  ivw_core_model i_ivw_core_model (.i_clk(i_clk), .i_srst(i_srst),
    .i_take(take), .i_delay(dly), .o_ret(ret));

  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  task automatic chk(input logic [15:0] seen, exp, input string what);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t ns: %s", $time, what);
    end
  endtask : chk

  function automatic logic [31:0] lf(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lf

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= v;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    v = o_rdata;
  endtask : rd

  // Model pick: enables first, then lowest level, then lowest group
  function automatic int pick(input logic [15:0] r, input logic [4:0] c);
    logic [15:0] q;
    int          b;
    q = r & {5'h0, c[4] & c[0], {4{c[0]}}, c[3] & c[0], {3{c[0]}},
             c[2] & c[0], c[1]};
    b = -1;
    for (int g = 0; g < 16; g++)
      if (q[g] && lv[g] < 3 && (b < 0 || lv[g] < lv[b]))
        b = g;
    return b;
  endfunction : pick

  // Raise sources, optionally open a window, then follow the take
  task automatic run(input logic [15:0] r, input int exp, input int mode);
    logic [15:0] v;
    s = lf(s);
    v = s[15:0];
    @(posedge i_clk);
    pf <= r[0];
    {swf, srf, uwf, urf} <= r[1] ? 4'h1 << s[17:16] : 4'h0;
    spi0    <= r[5] ? 4'h1 << s[19:18] : 4'h0;
    spi1    <= r[10] ? 4'h1 << s[21:20] : 4'h0;
    misc    <= {r[9:6], r[4:2]};
    dly     <= s[24:22];
    i_addr  <= ivw_pkg::ADDR_PREFIX;
    i_wdata <= v;
    i_wr    <= (mode == 1);
    fork
      begin
        @(posedge i_clk);
        i_wr <= 1'b0;
        cpa  <= (mode == 2);
        #1;
        if (mode == 1)
          chk(prefix_val, v, "prefix value");
        @(posedge i_clk);
        cpa <= 1'b0;
      end
    join_none
    for (n = 1; n < 13; n++)
    begin
      @(posedge i_clk);
      #1;
      if (take === 1'b1)
        break;
    end
    if (exp < 0)
      chk(16'(n), 16'd13, "service while gated");
    else
    begin
      chk(16'(n), 16'(2 + (mode != 0)), "latency");
      chk(vec, 16'(32 + 8 * exp), "vector");
      chk(svc_lvl, 16'(lv[exp]), "service level");
    end
    // Dropping flags at once keeps the same source from firing again
    @(posedge i_clk);
    {pf, swf, srf, uwf, urf, spi0, spi1, misc} <= '0;
    if (exp >= 0)
    begin
      for (n = 0; n < 12 && ret !== 1'b1; n++)
        @(posedge i_clk);
      @(posedge i_clk);
      #1;
      chk(svc_lvl, 16'h0003, "return level");
    end
  endtask : run

  task automatic results();
    if (error_cnt == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  // Span is many times the expected run of about six hundred cycles
  initial
  begin
    #80000;
    error_cnt++;
    results();
  end

  initial
  begin
    {i_srst, i_wr, i_rd, i_addr, i_wdata} = {1'b1, 22'h0};
    {pf, swf, srf, uwf, urf, spi0, spi1, misc, cpa, dly} = '0;
    repeat (20) @(posedge i_clk);
    i_srst <= 1'b0;
    #1;
    chk(vec, 16'h0020, "vector at reset");
    // Reset values, prefix read and an unmapped index
    for (e = 0; e < 8; e++)
    begin
      rd(4'(e), d);
      chk(d, (e == 6) ? 16'h0003 : 16'h0000, "reset value");
    end
    repeat (24)
    begin
      for (e = 0; e < 2; e++)
      begin
        s = lf(s);
        wr(4'(ivw_pkg::ADDR_PRIO_LOW + e), s[15:0]);
        rd(4'(ivw_pkg::ADDR_PRIO_LOW + e), d);
        chk(d, s[15:0], "priority readback");
        for (n = 0; n < 8; n++)
          lv[8 * e + n] = int'((s[15:0] >> (2 * n)) & 16'h3);
      end
      s   = lf(s);
      ctl = s[4:0];
      wr(ivw_pkg::ADDR_CTRL, {11'h0, ctl});
      s = lf(s);
      m = s[15:0] & 16'h07ff;
      run(m, pick(m, ctl), 0);
    end
    // Same request, plain and behind each kind of window
    wr(ivw_pkg::ADDR_PRIO_LOW, 16'h0000);
    wr(ivw_pkg::ADDR_CTRL, 16'h001f);
    lv[2] = 0;
    for (e = 0; e < 3; e++)
      run(16'h0004, 2, e);
    rd(ivw_pkg::ADDR_STATUS, d);
    chk(d, 16'h0003, "status after window");
    chk(irq, 16'h0000, "masked interrupt");
    wr(ivw_pkg::ADDR_MASK, 16'h0001);
    repeat (2) @(posedge i_clk);
    #1;
    chk(irq, 16'h0001, "unmasked interrupt");
    wr(ivw_pkg::ADDR_STATUS, 16'h0003);
    repeat (2) @(posedge i_clk);
    #1;
    chk(irq, 16'h0000, "cleared interrupt");
    rd(ivw_pkg::ADDR_STATUS, d);
    chk(d, 16'h0000, "status cleared");
    results();
  end
endmodule : tb_interrupt_vector_priority_window
